/* rtl/rtc_pkg.sv */
package rtc_pkg;
    // clock and time-base rates
    localparam int CLK_HZ = 20_000_000; // system clock rate
    localparam int TB_HZ = 32_768; // oscillator time base
    localparam int MS_HZ = 1_000; // thousandths step rate
    localparam int ACC_W = 26; // phase accumulator width
    localparam int NWORD = 8; // counter words, same count of latch words

    // address map, five-bit codes
    localparam logic [4:0] A_LAT = 5'h08; // first latch word
    localparam logic [4:0] A_ISTAT = 5'h10; // interrupt status, read clears
    localparam logic [4:0] A_IMASK = 5'h11; // interrupt mask, write only
    localparam logic [4:0] A_CRST = 5'h12; // counter reset
    localparam logic [4:0] A_LRST = 5'h13; // latch reset
    localparam logic [4:0] A_STAT = 5'h14; // rollover status bit
    localparam logic [4:0] A_GO = 5'h15; // go command
    localparam logic [4:0] A_STBY = 5'h16; // standby interrupt enable
    localparam logic [4:0] A_TEST = 5'h1F; // test mode, accepted, no effect

    // word indexes
    localparam int W_MS = 0; // thousandths
    localparam int W_TH = 1; // tenths and hundredths
    localparam int W_SEC = 2; // seconds
    localparam int W_MIN = 3; // minutes
    localparam int W_HR = 4; // hours
    localparam int W_WD = 5; // day of week
    localparam int W_MD = 6; // day of month
    localparam int W_MON = 7; // month

    // implemented bits of each counter word
    localparam logic [7:0] WMASK [NWORD] = '{8'hF0, 8'hFF, 8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F};

    // bcd limits
    localparam logic [7:0] ZERO = 8'h00; // reset and wrap value
    localparam logic [7:0] BOT = 8'h01; // wrap value of one-based words
    localparam logic [7:0] MS_STEP = 8'h10; // thousandths digit sits high
    localparam logic [7:0] TOP_MS = 8'h90;
    localparam logic [7:0] TOP_TH = 8'h99;
    localparam logic [7:0] TOP_SEC = 8'h59;
    localparam logic [7:0] TOP_HR = 8'h23;
    localparam logic [7:0] TOP_WD = 8'h07;
    localparam logic [7:0] TOP_MON = 8'h12;
    localparam logic [7:0] MD_LONG = 8'h31;
    localparam logic [7:0] MD_SHORT = 8'h30;
    localparam logic [7:0] MD_FEB = 8'h29;
    localparam logic [7:0] M_FEB = 8'h02;
    localparam logic [7:0] M_APR = 8'h04;
    localparam logic [7:0] M_JUN = 8'h06;
    localparam logic [7:0] M_SEP = 8'h09;
    localparam logic [7:0] M_NOV = 8'h11;
    localparam logic [3:0] DIG_MAX = 4'h9; // last bcd digit
    localparam logic [3:0] DIG_ONE = 4'h1;
    localparam logic [3:0] DIG_ZERO = 4'h0;
    localparam logic [1:0] NIB_DC = 2'b11; // top two bits of a latch nibble mark don't care

    // interrupt status bit positions
    localparam int IB_MATCH = 0;
    localparam int IB_TENTH = 1;
    localparam int IB_SEC = 2;
    localparam int IB_MIN = 3;
    localparam int IB_HOUR = 4;
    localparam int IB_DAY = 5;
    localparam int IB_WEEK = 6;
    localparam int IB_MONTH = 7;

    // pins as sampled from the outside
    typedef struct packed {
        logic pwrdn_n; // low selects power down
        logic cs_n; // chip select
        logic rd_n; // read strobe
        logic wr_n; // write strobe
        logic [4:0] addr; // word address
        logic [7:0] data; // write data
    } rtc_pins_t;

    // idle level of the pins while in reset
    localparam rtc_pins_t PINS_IDLE = '{pwrdn_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
        addr: 5'h00, data: 8'h00};

    // bus cycle states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, // waiting for a strobe
        ST_BUSY = 2'b01, // access carried out
        ST_DONE = 2'b10 // ready released, waiting for strobe end
    } rtc_state_t;
endpackage : rtc_pkg

/* rtl/rtc_sync.sv */
`timescale 1ns/1ps
module rtc_sync import rtc_pkg::*; #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] s1_r, s2_r, s3_r, out_r; // three stages and the filtered level
    logic [W-1:0] out_nxt;

    // a bit changes only once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
            end
        end
    endgenerate

    // stage registers
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            out_r <= RST;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign o_sync = out_r;
endmodule : rtc_sync

/* rtl/rtc_tbase.sv */
`timescale 1ns/1ps
module rtc_tbase import rtc_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_go,
    output logic o_tb_tick,
    output logic o_ms_tick
);
    localparam logic [ACC_W-1:0] K_CLK = ACC_W'(CLK_HZ);
    localparam logic [ACC_W-1:0] K_TB = ACC_W'(TB_HZ);
    localparam logic [ACC_W-1:0] K_MS = ACC_W'(MS_HZ);

    logic [ACC_W-1:0] tacc_r, tacc_nxt; // oscillator phase in system clocks
    logic [ACC_W-1:0] macc_r, macc_nxt; // thousandths phase in time-base ticks
    logic tb, ms;

    // fractional dividers: 32768 Hz from the system clock, 1 kHz from that
    always_comb begin
        tacc_nxt = tacc_r + K_TB;
        tb = 1'b0;
        if (tacc_nxt >= K_CLK) begin
            tacc_nxt = tacc_nxt - K_CLK;
            tb = 1'b1;
        end
        macc_nxt = macc_r;
        ms = 1'b0;
        if (tb) begin
            macc_nxt = macc_r + K_MS;
            if (macc_nxt >= K_TB) begin
                macc_nxt = macc_nxt - K_TB;
                ms = 1'b1;
            end
        end
        // go restarts the sub-second phase
        if (i_go) begin
            macc_nxt = '0;
            ms = 1'b0;
        end
    end

    // phase registers
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            tacc_r <= '0;
            macc_r <= '0;
        end else begin
            tacc_r <= tacc_nxt;
            macc_r <= macc_nxt;
        end
    end

    assign o_tb_tick = tb;
    assign o_ms_tick = ms;
endmodule : rtc_tbase

/* rtl/rtc_top.sv */
`timescale 1ns/1ps
// Contract
// - counters and alarm latches, thousandths to months
// - each word two bcd nibbles, own address
// - unused counter bits ignored, read low
// - illegal bcd recovers within four increments
// - latches keep all eight written bits
// - any word cleared by reset write
// - latch nibble top bits set means don't care
// - don't care chosen per nibble
// - maskable interrupt, eight sources
// - power down: only standby interrupt stays active
// - rollover during counter read sets status
// - counting derives from 32768 Hz time base
// - thousandths word: low nibble zero
// - tenths and hundredths both count 0-9
// - five-bit address selects words and commands
// - reading interrupt status clears it and output
// - status bit on d0, rest zero
// - ready low until data valid or latched
module rtc_top import rtc_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_pwrdn_n,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe_n,
    output logic o_rdy,
    output logic o_rdy_oe_n,
    output logic o_int,
    output logic o_int_oe_n,
    output logic o_stby,
    output logic o_stby_oe_n
);
    rtc_pins_t pin; // filtered pins
    logic tb_tick, ms_tick; // time-base and thousandths enables
    logic go_pulse; // go command write

    // synchronise all pins before use
    rtc_sync #(.W($bits(rtc_pins_t)), .RST(PINS_IDLE)) u_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_async({i_pwrdn_n, i_cs_n, i_rd_n, i_wr_n, i_addr, i_data}),
        .o_sync(pin)
    );

    // time base dividers
    rtc_tbase u_tbase (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_go(go_pulse),
        .o_tb_tick(tb_tick),
        .o_ms_tick(ms_tick)
    );

    // ---------------- bus cycle ----------------
    rtc_state_t state_r, state_nxt;
    logic pwr; // powered, not in power down
    logic cyc_rd, cyc_wr, cyc; // strobe decode
    logic do_rd, do_wr; // one-cycle access strobes
    logic [7:0] rdata_r, rdata_nxt; // read data register
    logic [7:0] rmux; // read selection

    assign pwr = pin.pwrdn_n;
    assign cyc_rd = pwr && !pin.cs_n && !pin.rd_n && pin.wr_n;
    assign cyc_wr = pwr && !pin.cs_n && pin.rd_n && !pin.wr_n;
    assign cyc = cyc_rd || cyc_wr;
    assign do_rd = (state_r == ST_BUSY) && cyc_rd;
    assign do_wr = (state_r == ST_BUSY) && cyc_wr;
    assign go_pulse = do_wr && (pin.addr == A_GO);

    // cycle sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cyc) begin
                    state_nxt = ST_BUSY;
                end
            end
            ST_BUSY: begin
                state_nxt = ST_DONE;
            end
            ST_DONE: begin
                if (!cyc) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ready pulled low from strobe until the access has been done
    assign o_rdy = 1'b0;
    assign o_rdy_oe_n = !(cyc && (state_r != ST_DONE));

    // data bus driven only while a selected read is in progress
    assign o_data = rdata_r;
    assign o_data_oe_n = !cyc_rd;

    // ---------------- counters and latches ----------------
    logic [7:0] cnt_r [NWORD]; // counter words
    logic [7:0] cnt_nxt [NWORD];
    logic [7:0] lat_r [NWORD]; // alarm latch words
    logic [7:0] lat_nxt [NWORD];
    logic [8:0] s_ms, s_th, s_sec, s_min, s_hr, s_wd, s_md, s_mon; // {carry, next}
    logic c_ms, c_th, c_sec, c_min, c_hr, c_wd, c_md;
    logic [7:0] ev; // counter events into interrupt status

    // one step of a two-digit word; wraps on any value at or above the top
    function automatic logic [8:0] inc_w(input logic [7:0] v, input logic [7:0] top, input logic [7:0] bot);
        logic [8:0] r;
        r = {1'b0, v[7:4], v[3:0] + DIG_ONE};
        if (v >= top) begin
            r = {1'b1, bot};
        end else if (v[3:0] >= DIG_MAX) begin
            r = {1'b0, v[7:4] + DIG_ONE, DIG_ZERO};
        end
        return r;
    endfunction : inc_w

    // last monthday_counter, february fixed at 29
    function automatic logic [7:0] md_top(input logic [7:0] m);
        logic [7:0] r;
        case (m)
            M_FEB: r = MD_FEB;
            M_APR, M_JUN, M_SEP, M_NOV: r = MD_SHORT;
            default: r = MD_LONG;
        endcase
        return r;
    endfunction : md_top

    // count, then let bus writes override
    always_comb begin
        cnt_nxt = cnt_r;
        lat_nxt = lat_r;
        ev = '0;
        s_ms = (cnt_r[W_MS] >= TOP_MS) ? {1'b1, ZERO} : {1'b0, cnt_r[W_MS] + MS_STEP};
        s_th = inc_w(cnt_r[W_TH], TOP_TH, ZERO);
        s_sec = inc_w(cnt_r[W_SEC], TOP_SEC, ZERO);
        s_min = inc_w(cnt_r[W_MIN], TOP_SEC, ZERO);
        s_hr = inc_w(cnt_r[W_HR], TOP_HR, ZERO);
        s_wd = inc_w(cnt_r[W_WD], TOP_WD, BOT);
        s_md = inc_w(cnt_r[W_MD], md_top(cnt_r[W_MON]), BOT);
        s_mon = inc_w(cnt_r[W_MON], TOP_MON, BOT);
        c_ms = ms_tick && s_ms[8];
        c_th = c_ms && s_th[8];
        c_sec = c_th && s_sec[8];
        c_min = c_sec && s_min[8];
        c_hr = c_min && s_hr[8];
        c_wd = c_hr && s_wd[8];
        c_md = c_hr && s_md[8];
        if (ms_tick) cnt_nxt[W_MS] = s_ms[7:0];
        if (c_ms) cnt_nxt[W_TH] = s_th[7:0];
        if (c_th) cnt_nxt[W_SEC] = s_sec[7:0];
        if (c_sec) cnt_nxt[W_MIN] = s_min[7:0];
        if (c_min) cnt_nxt[W_HR] = s_hr[7:0];
        if (c_hr) cnt_nxt[W_WD] = s_wd[7:0];
        if (c_hr) cnt_nxt[W_MD] = s_md[7:0];
        if (c_md) cnt_nxt[W_MON] = s_mon[7:0];
        // interrupt sources
        ev[IB_TENTH] = c_ms && (cnt_r[W_TH][3:0] >= DIG_MAX);
        ev[IB_SEC] = c_th;
        ev[IB_MIN] = c_sec;
        ev[IB_HOUR] = c_min;
        ev[IB_DAY] = c_hr;
        ev[IB_WEEK] = c_wd;
        ev[IB_MONTH] = c_md;
        // bus writes
        if (do_wr) begin
            if (pin.addr < A_LAT) begin
                cnt_nxt[pin.addr[2:0]] = pin.data;
            end else if (pin.addr < A_ISTAT) begin
                lat_nxt[pin.addr[2:0]] = pin.data;
            end else if (pin.addr == A_GO) begin
                cnt_nxt[W_MS] = ZERO;
                cnt_nxt[W_TH] = ZERO;
                cnt_nxt[W_SEC] = ZERO;
            end
            for (int k = 0; k < NWORD; k++) begin
                if ((pin.addr == A_CRST) && pin.data[k]) cnt_nxt[k] = ZERO;
                if ((pin.addr == A_LRST) && pin.data[k]) lat_nxt[k] = ZERO;
            end
        end
        // unimplemented counter bits never store
        for (int k = 0; k < NWORD; k++) begin
            cnt_nxt[k] = cnt_nxt[k] & WMASK[k];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int k = 0; k < NWORD; k++) begin
                cnt_r[k] <= ZERO;
                lat_r[k] <= ZERO;
            end
        end else begin
            cnt_r <= cnt_nxt;
            lat_r <= lat_nxt;
        end
    end

    // ---------------- alarm comparison ----------------
    logic [2*NWORD-1:0] nib_ok; // per-nibble match or don't care
    logic match_now, match_r, match_nxt;

    genvar g;
    generate
        for (g = 0; g < 2*NWORD; g++) begin : g_nib
            always_comb begin
                nib_ok[g] = (lat_r[g/2][4*(g%2)+2 +: 2] == NIB_DC) ||
                    (lat_r[g/2][4*(g%2) +: 4] == cnt_r[g/2][4*(g%2) +: 4]);
            end
        end
    endgenerate

    assign match_now = &nib_ok;

    // comparator sampled every time-base tick
    always_comb begin
        match_nxt = tb_tick ? match_now : match_r;
    end

    // ---------------- status, mask, standby ----------------
    logic [7:0] ist_r, ist_nxt; // interrupt status
    logic [7:0] mask_r, mask_nxt; // interrupt mask
    logic roll_r, roll_nxt; // rollover status bit
    logic stby_r, stby_nxt; // standby interrupt enable
    logic cnt_read; // a counter word is being read

    assign cnt_read = cyc_rd && (pin.addr < A_LAT) && (state_r != ST_IDLE);

    // sticky flags; a new event wins over the clearing read
    always_comb begin
        ist_nxt = ist_r;
        mask_nxt = mask_r;
        roll_nxt = roll_r;
        stby_nxt = stby_r;
        if (do_rd && (pin.addr == A_ISTAT)) ist_nxt = '0;
        if (do_rd && (pin.addr == A_STAT)) roll_nxt = 1'b0;
        ist_nxt = ist_nxt | ev;
        ist_nxt[IB_MATCH] = ist_nxt[IB_MATCH] | (tb_tick && match_now);
        roll_nxt = roll_nxt | (ms_tick && cnt_read);
        if (do_wr && (pin.addr == A_IMASK)) mask_nxt = pin.data;
        if (do_wr && (pin.addr == A_STBY)) stby_nxt = pin.data[0];
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ist_r <= '0;
            mask_r <= '0;
            roll_r <= 1'b0;
            stby_r <= 1'b0;
            match_r <= 1'b0;
        end else begin
            ist_r <= ist_nxt;
            mask_r <= mask_nxt;
            roll_r <= roll_nxt;
            stby_r <= stby_nxt;
            match_r <= match_nxt;
        end
    end

    // read selection; mask and command addresses read zero
    always_comb begin
        rmux = ZERO;
        if (pin.addr < A_LAT) rmux = cnt_r[pin.addr[2:0]];
        else if (pin.addr < A_ISTAT) rmux = lat_r[pin.addr[2:0]];
        else if (pin.addr == A_ISTAT) rmux = ist_r;
        else if (pin.addr == A_STAT) rmux = {7'h00, roll_r};
        rdata_nxt = do_rd ? rmux : rdata_r;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_r <= ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // interrupt pins; standby sinks on match whether powered or not
    assign o_int = |(ist_r & mask_r);
    assign o_int_oe_n = !pwr;
    assign o_stby = 1'b0;
    assign o_stby_oe_n = !(stby_r && match_r);

    // ---------------- checks ----------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    AST_RDY_LOW: assert property ((state_r == ST_IDLE) && cyc |-> !o_rdy_oe_n ##1 !o_rdy_oe_n)
        else $error("ready not held low at cycle start");
    AST_RDY_REL: assert property (do_rd |=> o_rdy_oe_n && (o_data == $past(rmux)))
        else $error("ready released without valid data");
    AST_WD_BITS: assert property ((cnt_r[W_WD] & ~WMASK[W_WD]) == ZERO)
        else $error("unused weekday bits set");
    AST_MS_LOW: assert property (cnt_r[W_MS][3:0] == DIG_ZERO)
        else $error("thousandths low nibble not zero");
    AST_LAT_WR: assert property (do_wr && (pin.addr >= A_LAT) && (pin.addr < A_ISTAT)
        |=> lat_r[$past(pin.addr[2:0])] == $past(pin.data))
        else $error("latch did not keep written value");
    AST_ISTAT_CLR: assert property (do_rd && (pin.addr == A_ISTAT) && !tb_tick |=> (ist_r == '0) && !o_int)
        else $error("status read did not clear interrupt");
    AST_ROLL: assert property (ms_tick && cnt_read |=> roll_r)
        else $error("rollover during read not flagged");
    AST_STAT_FMT: assert property (do_rd && (pin.addr == A_STAT) |=> o_data[7:1] == 7'h00)
        else $error("status read upper bits not zero");
    AST_DC_ALL: assert property ((lat_r[W_HR][7:6] == NIB_DC) && (lat_r[W_HR][3:0] == cnt_r[W_HR][3:0])
        |-> nib_ok[2*W_HR+1] && nib_ok[2*W_HR])
        else $error("don't care nibble failed to match");
    AST_PD: assert property (!pwr |-> o_int_oe_n && o_rdy_oe_n && o_data_oe_n)
        else $error("output active in power down");
    AST_STBY: assert property (tb_tick && match_now && stby_r |=> !o_stby_oe_n)
        else $error("standby interrupt not asserted on match");
    AST_SEC_WRAP: assert property (c_th && (cnt_r[W_SEC] == TOP_SEC) && !do_wr |=> cnt_r[W_SEC] == ZERO)
        else $error("seconds did not wrap");
    AST_INT_SRC: assert property (ev[IB_SEC] && mask_r[IB_SEC] && !do_wr |=> o_int)
        else $error("masked-in event did not interrupt");

    COV_READ: cover property (do_rd ##1 (state_r == ST_DONE) ##[1:20] (state_r == ST_IDLE));
    COV_WRITE: cover property (do_wr && (pin.addr == A_CRST));
    COV_MATCH: cover property (tb_tick && match_now && stby_r);
    COV_ROLL: cover property (ms_tick && cnt_read);
endmodule : rtc_top

/* sim/rtc_cpu.sv */
`timescale 1ns/1ps
// processor model: one strobed cycle at a time, paced by the ready line
module rtc_cpu (
    input wire logic i_mclk,
    input wire logic i_rdy, // ready line level, pulled up when released
    input wire logic [7:0] i_bus, // data bus level
    output logic o_cs_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [4:0] o_addr,
    output logic [7:0] o_data
);
    // idle pins from time zero
    initial begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_addr = 5'h00;
        o_data = 8'h00;
    end

    // wait up to 12 clocks for the ready line to reach a level
    task automatic wait_rdy(input logic lvl, output bit ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 12 && !ok; n++) begin
            @(posedge i_mclk);
            #1;
            ok = (i_rdy === lvl);
        end
    endtask : wait_rdy

    // one bus cycle; ok low when ready never dropped (refused)
    task automatic cyc(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q, output bit ok);
        bit hi;
        @(posedge i_mclk);
        #2;
        o_addr = a;
        o_data = wr ? d : ~o_data; // released bus never holds the old value
        o_cs_n = 1'b0;
        o_rd_n = wr;
        o_wr_n = !wr;
        wait_rdy(1'b0, ok);
        wait_rdy(1'b1, hi);
        ok = ok & hi;
        q = i_bus;
        // hold everything through the edge that sees ready high
        @(posedge i_mclk);
        #2;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_data = ~o_data;
        // strobe end must pass the pin filter before the next cycle
        repeat (6) @(posedge i_mclk);
    endtask : cyc
endmodule : rtc_cpu

/* sim/rtc_top_tb.sv */
`timescale 1ns/1ps
module rtc_top_tb import rtc_pkg::*; ;
    logic mclk, rst, pwrdn_n, cs_n, rd_n, wr_n, data_oe_n, rdy_w, rdy_oe_n, irq, int_oe_n, stby, stby_oe_n;
    logic [4:0] addr;
    logic [7:0] cpu_d, dout;
    wire logic [7:0] bus = data_oe_n ? cpu_d : dout; // device drives only when enabled
    wire logic rdy = rdy_oe_n ? 1'b1 : rdy_w; // open drain with pull-up
    wire logic stby_pin = stby_oe_n ? 1'b1 : stby; // standby line, open drain with pull-up
    int errors = 0;
    int tests_run = 0;

    rtc_top i_dut (.i_mclk(mclk), .i_rst(rst), .i_pwrdn_n(pwrdn_n), .i_cs_n(cs_n), .i_rd_n(rd_n),
        .i_wr_n(wr_n), .i_addr(addr), .i_data(bus), .o_data(dout), .o_data_oe_n(data_oe_n), .o_rdy(rdy_w),
        .o_rdy_oe_n(rdy_oe_n), .o_int(irq), .o_int_oe_n(int_oe_n), .o_stby(stby), .o_stby_oe_n(stby_oe_n));
    rtc_cpu i_cpu (.i_mclk(mclk), .i_rdy(rdy), .i_bus(bus), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_addr(addr), .o_data(cpu_d));

    // 50 ns clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // verdict, single exit point
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // compare and count
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask : check

    // register write through the pin bus
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bit ok;
        i_cpu.cyc(1'b1, a, d, q, ok);
        check("write ready", {7'h00, ok}, 8'h01);
    endtask : wr

    // register read, compared with an expected word
    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bit ok;
        i_cpu.cyc(1'b0, a, 8'h00, q, ok);
        check("read ready", {7'h00, ok}, 8'h01);
        check(nm, q, exp);
    endtask : rd_chk

    // state after reset
    task automatic t_reset();
        logic [7:0] q;
        bit ok;
        check("int", {7'h00, irq}, 8'h00);
        check("stby", {7'h00, stby_oe_n}, 8'h01);
        rd_chk("hours", 5'(W_HR), 8'h00);
        rd_chk("month latch", A_LAT + 5'(W_MON), 8'h00);
        i_cpu.cyc(1'b0, 5'(W_MS), 8'h00, q, ok);
        check("ms low nibble", {4'h0, q[3:0]}, 8'h00);
    endtask : t_reset

    // unused counter bits read low, latches keep all bits
    task automatic t_masks();
        for (int i = W_SEC; i < NWORD; i++) begin
            wr(5'(i), 8'hFF);
            rd_chk("counter mask", 5'(i), WMASK[i]);
        end
        for (int i = 0; i < NWORD; i++) begin
            wr(A_LAT + 5'(i), 8'h5A ^ 8'(i));
            rd_chk("latch word", A_LAT + 5'(i), 8'h5A ^ 8'(i));
        end
    endtask : t_masks

    // per-word clear through the reset commands, odd addresses
    task automatic t_words();
        wr(A_CRST, 8'hFC);
        for (int i = W_SEC; i < NWORD; i++) rd_chk("counter clear", 5'(i), 8'h00);
        wr(A_LRST, 8'h08);
        rd_chk("latch clear", A_LAT + 5'(W_MIN), 8'h00);
        rd_chk("latch kept", A_LAT + 5'(W_HR), 8'h5E);
        rd_chk("status bit", A_STAT, 8'h00);
        rd_chk("mask read", A_IMASK, 8'h00);
        wr(A_TEST, 8'hFF);
        rd_chk("unmapped", 5'h18, 8'h00);
    endtask : t_words

    // go command clears the low words, then one thousandths tick carries into minutes
    task automatic t_carry();
        wr(5'(W_MS), 8'h50);
        wr(5'(W_SEC), 8'h33);
        wr(A_GO, 8'h00);
        rd_chk("go ms", 5'(W_MS), 8'h00);
        rd_chk("go sec", 5'(W_SEC), 8'h00);
        wr(A_IMASK, 8'h04);
        wr(5'(W_MS), 8'h90);
        wr(5'(W_TH), 8'h99);
        wr(5'(W_SEC), 8'h59);
        // next thousandths tick comes 33 time-base ticks after go
        for (int n = 0; n < 22000 && !irq; n++) begin
            @(posedge mclk);
            #1;
        end
        check("second int", {7'h00, irq}, 8'h01);
        rd_chk("th wrap", 5'(W_TH), 8'h00);
        rd_chk("sec wrap", 5'(W_SEC), 8'h00);
        rd_chk("min carry", 5'(W_MIN), 8'h01);
        rd_chk("carry stat", A_ISTAT, 8'h0E);
        check("int acked", {7'h00, irq}, 8'h00);
    endtask : t_carry

    // alarm compare with per-nibble don't care, interrupt and standby
    task automatic t_match();
        // seconds latch mismatches before the rest turn don't care, so no early match
        for (int i = 0; i < NWORD; i++) begin
            wr(A_LAT + 5'(i), (i == W_SEC) ? 8'hF1 : (i == W_HR) ? 8'hC0 : 8'hFF);
        end
        wr(A_IMASK, 8'h01);
        wr(A_STBY, 8'h01);
        repeat (1400) @(posedge mclk);
        check("no match stby", {7'h00, stby_oe_n}, 8'h01);
        rd_chk("no match stat", A_ISTAT, 8'h00);
        wr(A_LAT + 5'(W_SEC), 8'hF0);
        repeat (1400) @(posedge mclk);
        check("match int", {7'h00, irq}, 8'h01);
        check("match stby", {7'h00, stby_pin}, 8'h00);
        wr(A_LAT + 5'(W_SEC), 8'h59);
        repeat (1400) @(posedge mclk);
        check("sticky int", {7'h00, irq}, 8'h01);
        rd_chk("match stat", A_ISTAT, 8'h01);
        check("int cleared", {7'h00, irq}, 8'h00);
        check("stby off", {7'h00, stby_oe_n}, 8'h01);
    endtask : t_match

    // power down leaves only the standby output alive
    task automatic t_pwrdn();
        logic [7:0] q;
        bit ok;
        wr(A_LAT + 5'(W_SEC), 8'hF0);
        @(posedge mclk);
        #2;
        pwrdn_n = 1'b0;
        repeat (1400) @(posedge mclk);
        check("int off", {7'h00, int_oe_n}, 8'h01);
        check("stby on", {7'h00, stby_pin}, 8'h00);
        i_cpu.cyc(1'b0, A_ISTAT, 8'h00, q, ok);
        check("refused", {7'h00, ok}, 8'h00);
        check("data off", {7'h00, data_oe_n}, 8'h01);
        @(posedge mclk);
        #2;
        pwrdn_n = 1'b1;
        repeat (8) @(posedge mclk);
        check("int back", {7'h00, int_oe_n}, 8'h00);
    endtask : t_pwrdn

    // main sequence
    initial begin
        rst = 1'b1;
        pwrdn_n = 1'b1;
        repeat (8) @(posedge mclk);
        #2;
        rst = 1'b0;
        repeat (4) @(posedge mclk);
        t_reset();
        t_masks();
        t_words();
        t_carry();
        t_match();
        t_pwrdn();
        finish_test();
    end

    // watchdog well past the expected run length
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        finish_test();
    end
endmodule : rtc_top_tb
